// ==== pscl_loader.sv ====
// Write-only serial control register and static configuration decode of the synchronizer
`timescale 1ns/1ns
// Functional notes
// - The control word is six bits and exactly six bits are taken into the register.
// - While load enable is low, serial bits are accepted into the shift path.
// - The word is latched when its sixth bit is shifted in, and applied to the controlled circuits when load enable goes high.
// - Serial data is sampled on each falling edge of the serial clock, held stable by the loader.
// - Bits 0 to 4 choose one of 32 early/late positions of the data window strobe.
// - Three band-select pins choose the oscillator range from 0.50 MHz up to 48.0 MHz.
// - Two preamble-select pins set the sync matching divider modulus to 1, 2, 3 or 4.
module pscl_loader
   import pscl_pkg::*;
(
   input  wire logic       core_clk,
   input  wire logic       rst,
   input  wire logic       ctrl_serial_clk,
   input  wire logic       ctrl_load_enable,
   input  wire logic       ctrl_serial_in,
   input  wire logic       vco_band_sel0,
   input  wire logic       vco_band_sel1,
   input  wire logic       vco_band_sel2,
   input  wire logic       preamble_modulus_sel0,
   input  wire logic       preamble_modulus_sel1,
   output pscl_ctrl_t      ctrl_out,
   output pscl_cfg_t       cfg_out,
   output logic            ctrl_loaded
);
   import pscl_pkg::*;

   // =====================================================================
   // Decode helpers
   function automatic pscl_band_t band_decode(input logic [2:0] code);
      pscl_band_t b;
      b = PSCL_BAND_20M0_48M0;
      if (code[2:1] == 2'b11) begin
         b = PSCL_BAND_0M50_1M25;
      end else if (code == BAND_CODE_101) begin
         b = PSCL_BAND_1M25_2M5;
      end else if (code == BAND_CODE_100) begin
         b = PSCL_BAND_2M5_5M0;
      end else if (code == BAND_CODE_011) begin
         b = PSCL_BAND_5M0_10M0;
      end else if (code == BAND_CODE_010) begin
         b = PSCL_BAND_10M0_20M0;
      end
      return b;
   endfunction

   // =====================================================================
   // Link domain: runs on the falling edge of the serial clock
   pscl_link_t link_reg;
   pscl_link_t link_next;

   always_comb begin
      link_next       = link_reg;
      link_next.shift = {link_reg.shift[4:0], ctrl_serial_in};
      if (link_reg.count != 3'(CTRL_WIDTH)) begin
         link_next.count = link_reg.count + 3'h1;
      end
      // Capture once six bits are in; extra edges only keep the last six
      if (link_next.count == 3'(CTRL_WIDTH)) begin
         link_next.word = link_next.shift;
         link_next.full = 1'b1;
      end
   end

   // The serial clock stops between words, so the enable level itself
   // clears the bit count; the word is held for the core side to take.
   always_ff @(negedge ctrl_serial_clk or posedge ctrl_load_enable) begin
      if (ctrl_load_enable) begin
         link_reg.count <= CNT_RESET;
         link_reg.full  <= 1'b0;
      end else begin
         link_reg <= link_next;
      end
   end

   // =====================================================================
   // Core domain
   pscl_core_t core_reg;
   pscl_core_t core_next;
   logic [1:0] en_sync;
   logic [4:0] pin_sync0;
   logic [4:0] pin_sync1;
   logic [5:0] word_hold0;
   logic [5:0] word_hold1;
   logic       en_rise;

   assign en_rise = en_sync[1] && !core_reg.en_prev;

   // Two-flop synchronisers for the enable, static pins and captured word
   always_ff @(posedge core_clk) begin
      en_sync    <= {en_sync[0], ctrl_load_enable};
      pin_sync0  <= {vco_band_sel2, vco_band_sel1, vco_band_sel0, preamble_modulus_sel1, preamble_modulus_sel0};
      pin_sync1  <= pin_sync0;
      word_hold0 <= link_reg.word;
      word_hold1 <= word_hold0;
   end

   always_comb begin
      core_next = core_reg;
      core_next.full_sync = {core_reg.full_sync[0], link_reg.full};
      core_next.en_prev   = en_sync[1];
      // Apply only on the enable rise so a half-shifted word never reaches the strobe;
      // the held word has been stable for many core cycles by then.
      if (en_rise) begin
         if (core_reg.armed) begin
            core_next.ctrl.strobe_pos = word_hold1[STROBE_LSB +: STROBE_WIDTH];
            core_next.ctrl.test_mode  = word_hold1[TEST_BIT];
         end
         core_next.armed = 1'b0;
      end else if (!en_sync[1] && core_reg.full_sync[1]) begin
         // Arming only while shifting, so arm and apply never meet
         core_next.armed = 1'b1;
      end
      core_next.cfg.band    = band_decode(pin_sync1[4:2]);
      core_next.cfg.modulus = {1'b0, pin_sync1[1:0]} + 3'h1;
      if (rst) begin
         core_next.armed = 1'b0;
         core_next.ctrl  = pscl_ctrl_t'(CTRL_RESET);
      end
   end

   always_ff @(posedge core_clk) begin
      core_reg <= core_next;
   end

   logic loaded_reg;
   always_ff @(posedge core_clk) begin
      if (rst) begin
         loaded_reg <= 1'b0;
      end else if (en_rise && core_reg.armed) begin
         loaded_reg <= 1'b1;
      end
   end

   assign ctrl_out    = core_reg.ctrl;
   assign cfg_out     = core_reg.cfg;
   assign ctrl_loaded = loaded_reg;

endmodule

// ==== pscl_loader_monitor.sv ====
// Assertion checker for the control-word loader ports
`timescale 1ns/1ns
module pscl_loader_monitor
   import pscl_pkg::*;
(
   input wire logic  core_clk,
   input wire logic  rst,
   input wire logic  ctrl_serial_clk,
   input wire logic  ctrl_load_enable,
   input wire logic  ctrl_serial_in,
   input wire logic  vco_band_sel0,
   input wire logic  vco_band_sel1,
   input wire logic  vco_band_sel2,
   input wire logic  preamble_modulus_sel0,
   input wire logic  preamble_modulus_sel1,
   input pscl_ctrl_t ctrl_out,
   input pscl_cfg_t  cfg_out,
   input wire logic  ctrl_loaded
);
   logic [5:0] sh = 6'h00;
   logic [2:0] bc;
   assign bc = {vco_band_sel2, vco_band_sel1, vco_band_sel0};
   // Mirror of the shift path, so an applied word can be traced to its six bits
   always @(negedge ctrl_serial_clk) if (!ctrl_load_enable) sh <= {sh[4:0], ctrl_serial_in};
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (rst);
   sequence band_still; $stable(bc) [*4]; endsequence
   sequence mod_still; $stable({preamble_modulus_sel1, preamble_modulus_sel0}) [*4]; endsequence
   word_apply_a: assert property (!$stable(ctrl_out) |-> ctrl_out == {sh[4:0], sh[5]})
      else $error("applied word wrong");
   first_load_a: assert property ($rose(ctrl_loaded) |-> ctrl_out == {sh[4:0], sh[5]})
      else $error("first word wrong");
   apply_gate_a: assert property (!$stable(ctrl_out) |-> ctrl_load_enable && $past(ctrl_load_enable, 2))
      else $error("word applied while shifting");
   loaded_hold_a: assert property (ctrl_loaded |=> ctrl_loaded) else $error("loaded flag dropped");
   unloaded_zero_a: assert property (!ctrl_loaded |-> $past(ctrl_out) == 6'h00) else $error("early word");
   band_map_a: assert property (band_still |-> cfg_out.band == (bc == 3'h0 ? 3'h5 : bc == 3'h7 ? 3'h0 : 3'h6 - bc))
      else $error("band wrong");
   mod_map_a: assert property (mod_still |-> cfg_out.modulus == {1'b0, preamble_modulus_sel1, preamble_modulus_sel0} + 3'h1)
      else $error("modulus wrong");
   reset_clear_a: assert property (disable iff (1'b0) rst |=> ctrl_out == 6'h00 && !ctrl_loaded)
      else $error("reset did not clear");
endmodule
bind pscl_loader pscl_loader_monitor u_mon (.*);

// ==== pscl_loader_tb.sv ====
// Self-checking bench for the control-word loader
`timescale 1ns/1ns
module pscl_loader_tb;
   import pscl_pkg::*;
   logic core_clk = 1'b0;
   logic rst = 1'b1;
   logic ctrl_serial_clk, ctrl_load_enable, ctrl_serial_in, ctrl_loaded;
   logic [4:0] pins = 5'h00;
   pscl_ctrl_t ctrl_out;
   pscl_cfg_t cfg_out;
   logic [5:0] prev = 6'h00, w = 6'h00;
   logic [5:0] q[$];
   int errors = 0, n_compared = 0;
   initial forever #2 core_clk = ~core_clk;
   pscl_ser_model u_ldr (.*);
   pscl_loader u_dut (.vco_band_sel0(pins[2]), .vco_band_sel1(pins[3]), .vco_band_sel2(pins[4]),
      .preamble_modulus_sel0(pins[0]), .preamble_modulus_sel1(pins[1]), .*);
   task automatic cmp(input logic [5:0] exp, input logic [5:0] act);
      n_compared++;
      if (act !== exp) begin
         errors++;
         $display("[FAIL] %0t exp %h got %h", $time, exp, act);
      end
   endtask
   task automatic complete_run;
      $display("errors %0d compared %0d", errors, n_compared);
      if (errors == 0 && n_compared > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask
   task automatic load(input logic [5:0] wd, input int n);
      if (n == 6) q.push_back({wd[4:0], wd[5]});
      u_ldr.send(wd, n);
      repeat (20) @(posedge core_clk);
   endtask
   // =====================================
   // Result watcher: every change of the applied word takes the oldest note
   always @(posedge core_clk) begin
      if (!rst && ctrl_out !== prev)
         cmp(q.size() > 0 ? q.pop_front() : ~ctrl_out, ctrl_out);
      prev <= ctrl_out;
   end
   initial begin
      void'($urandom(85));
      repeat (10) @(posedge core_clk);
      rst <= 1'b0;
      for (int k = 0; k < 32; k++) begin
         pins <= k[4:0];
         repeat (6) @(posedge core_clk);
      end
      load(6'h1F, 5);
      for (int k = 0; k < 8; k++) begin
         w = {1'b0, w[4:0] ^ 5'($urandom_range(31, 1))};
         load(w, 6);
      end
      load({1'b1, w[4:0]}, 6);
      load(6'h2A, 4);
      rst <= 1'b1;
      repeat (3) @(posedge core_clk);
      rst <= 1'b0;
      load(6'h15, 6);
      cmp(6'h01, {5'h00, ctrl_loaded});
      if (q.size() != 0) errors++;
      complete_run;
   end
   // Twelve frames of about half a microsecond plus the pin sweep; far beyond that is a hang
   initial begin
      #100000;
      errors++;
      complete_run;
   end
endmodule

// ==== pscl_pkg.sv ====
// Package for the synchronizer control-word loader block: widths, field positions, enums and carriers
package pscl_pkg;

   // =====================================================================
   // Control word layout
   localparam int CTRL_WIDTH     = 6;
   localparam int STROBE_LSB     = 0;
   localparam int STROBE_WIDTH   = 5;
   localparam int TEST_BIT       = 5;
   localparam logic [5:0] CTRL_RESET = 6'h00;
   localparam logic [2:0] CNT_RESET  = 3'h0;

   // =====================================================================
   // Oscillator bands, from the slowest to the fastest
   typedef enum logic [2:0] {
      PSCL_BAND_0M50_1M25,
      PSCL_BAND_1M25_2M5,
      PSCL_BAND_2M5_5M0,
      PSCL_BAND_5M0_10M0,
      PSCL_BAND_10M0_20M0,
      PSCL_BAND_20M0_48M0
   } pscl_band_t;

   // Encoded pin values of the band select
   localparam logic [2:0] BAND_CODE_101 = 3'h5;
   localparam logic [2:0] BAND_CODE_100 = 3'h4;
   localparam logic [2:0] BAND_CODE_011 = 3'h3;
   localparam logic [2:0] BAND_CODE_010 = 3'h2;

   // =====================================================================
   // Carriers
   typedef struct packed {
      logic [4:0] strobe_pos;
      logic       test_mode;
   } pscl_ctrl_t;

   typedef struct packed {
      pscl_band_t band;
      logic [2:0] modulus;
   } pscl_cfg_t;

   // Link-side state, clocked by the falling edge of the serial clock
   typedef struct packed {
      logic [5:0] shift;
      logic [2:0] count;
      logic [5:0] word;
      logic       full;
   } pscl_link_t;

   // Core-side state
   typedef struct packed {
      logic [1:0] full_sync;
      logic       en_prev;
      logic       armed;
      pscl_ctrl_t ctrl;
      pscl_cfg_t  cfg;
   } pscl_core_t;

endpackage

// ==== pscl_ser_model.sv ====
// Partner model: the outside loader that shifts a control word in
`timescale 1ns/1ns
module pscl_ser_model (
   output logic ctrl_serial_clk = 1'b1,
   output logic ctrl_load_enable = 1'b0,
   output logic ctrl_serial_in = 1'b0
);
   // A first rise of the enable clears the far end's bit count before any frame
   initial #1 ctrl_load_enable = 1'b1;
   // Clock rests high between frames; data is inverted after use so stale bits never look valid
   task automatic send(input logic [5:0] w, input int n);
      #5 ctrl_load_enable = 1'b0;
      for (int i = 0; i < n; i++) begin
         ctrl_serial_in = w[5 - i];
         #32 ctrl_serial_clk = 1'b0;
         #32 ctrl_serial_clk = 1'b1;
      end
      #32 ctrl_load_enable = 1'b1;
      ctrl_serial_in = ~ctrl_serial_in;
   endtask
endmodule
